//--- inc/dbi_pkg.sv
// package: constants and types shared by the dram bank interface files
package dbi_pkg;
    // =====
    // clock and time base
    localparam int CLK_NS = 40;
    localparam int US_NS = 1000;
    localparam int US_CYC = US_NS / CLK_NS; // cycles per microsecond tick
    // =====
    // refresh periods in microseconds and their one-hot codes
    localparam logic [7:0] REF_US_16 = 8'h10;
    localparam logic [7:0] REF_US_32 = 8'h20;
    localparam logic [7:0] REF_US_64 = 8'h40;
    localparam logic [7:0] REF_US_128 = 8'h80;
    localparam logic [3:0] REF_CODE_16 = 4'h1;
    localparam logic [3:0] REF_CODE_32 = 4'h2;
    localparam logic [3:0] REF_CODE_64 = 4'h4;
    localparam logic [3:0] REF_CODE_128 = 4'h8;
    localparam logic [2:0] REF_REC_CYC = 3'h4;
    // =====
    // access timing in memory clocks
    localparam logic [2:0] PRE_DIFF = 3'h2;
    localparam logic [2:0] PRE_SAME = 3'h3;
    localparam logic [2:0] PRE_SAME_EXT = 3'h4;
    localparam logic [2:0] PRE_CNT_RST = 3'h4;
    localparam logic [1:0] RCD = 2'h2;
    localparam logic [1:0] RCD_EXT = 2'h3;
    localparam logic [7:0] BURST_MAX = 8'hFF;
    // =====
    // register map, fields and reset values
    localparam logic [31:0] ADDR_REFP = 32'h0320008C;
    localparam logic [31:0] ADDR_CFG = 32'h032000D0;
    localparam logic [31:0] ADDR_FORCE = 32'h032000D4;
    localparam logic [31:0] ADDR_STAT = 32'h032000D8;
    localparam logic [6:0] CFG_RST = 7'h00;
    localparam logic [7:0] FORCE_RST = 8'h00;
    localparam logic [3:0] REFP_RST = 4'h1;
    localparam int CFG_EDO_BIT = 4;
    localparam int CFG_RCD_BIT = 5;
    localparam int CFG_PRE_BIT = 6;
    // =====
    // state machines
    typedef enum logic [2:0] {S_IDLE, S_ROWA, S_RAS, S_CAS, S_TAIL, S_TAIL2} dbi_state_t;
    typedef enum logic [1:0] {R_IDLE, R_CAS, R_BOTH, R_REC} dbi_ref_state_t;
endpackage

//--- core/dbi_regs.sv
// apb register file: width/timing config, strobe forcing, refresh period, status
`timescale 1ns/1ps
module dbi_regs (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [2:0] i_status,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    output logic [6:0] o_cfg,
    output logic [7:0] o_force,
    output logic [3:0] o_refp
);
    // =====
    // decode: zero wait states, so the access phase always completes
    wire setup = i_psel & ~i_penable;
    wire wr_en = i_psel & i_penable & i_pwrite;
    wire hit_cfg = i_paddr == dbi_pkg::ADDR_CFG;
    wire hit_force = i_paddr == dbi_pkg::ADDR_FORCE;
    wire hit_refp = i_paddr == dbi_pkg::ADDR_REFP;
    wire hit_stat = i_paddr == dbi_pkg::ADDR_STAT;
    wire mapped = hit_cfg | hit_force | hit_refp | hit_stat;
    wire [31:0] rd_mux = hit_cfg ? {25'h0000000, o_cfg} :
                         hit_force ? {24'h000000, o_force} :
                         hit_refp ? {28'h0000000, o_refp} :
                         hit_stat ? {29'h00000000, i_status} : 32'h00000000;

    // =====
    // storage; read data is registered in the setup cycle
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cfg <= dbi_pkg::CFG_RST;
            o_force <= dbi_pkg::FORCE_RST;
            o_refp <= dbi_pkg::REFP_RST;
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else begin
            if (wr_en && hit_cfg) begin
                o_cfg <= i_pwdata[6:0];
            end
            if (wr_en && hit_force) begin
                o_force <= i_pwdata[7:0];
            end
            if (wr_en && hit_refp) begin
                o_refp <= i_pwdata[3:0];
            end
            if (setup) begin
                o_prdata <= rd_mux;
                o_pslverr <= ~mapped;
            end
        end
    end
endmodule // dbi_regs

//--- core/dbi_refresh.sv
// refresh interval timer and cas-before-ras refresh sequencer
`timescale 1ns/1ps
module dbi_refresh #(
    parameter int US_CYC = dbi_pkg::US_CYC
) (
    input wire logic i_clk,
    input wire logic i_por_b,
    input wire logic [3:0] i_period,
    input wire logic i_grant,
    output logic o_req,
    output logic o_busy,
    output logic o_ras,
    output logic o_cas
);
    // one-hot period code to microseconds; zero means refresh off
    function automatic logic [7:0] period_us(input logic [3:0] code);
        unique case (code)
            dbi_pkg::REF_CODE_16: period_us = dbi_pkg::REF_US_16;
            dbi_pkg::REF_CODE_32: period_us = dbi_pkg::REF_US_32;
            dbi_pkg::REF_CODE_64: period_us = dbi_pkg::REF_US_64;
            dbi_pkg::REF_CODE_128: period_us = dbi_pkg::REF_US_128;
            default: period_us = 8'h00;
        endcase
    endfunction

    logic [6:0] pre_r;
    logic [7:0] us_r;
    logic [2:0] rec_r;
    dbi_pkg::dbi_ref_state_t st_r;

    // =====
    // timer decode; undefined codes are treated as off
    wire [7:0] lim = period_us(i_period);
    wire tick = pre_r == 7'(US_CYC - 1);
    wire [8:0] us_inc = {1'b0, us_r} + 9'h001;
    wire due = tick & (lim != 8'h00) & (us_inc >= {1'b0, lim});
    wire start = (st_r == dbi_pkg::R_IDLE) & o_req & i_grant;

    // timer runs from power-on reset only, so it keeps going in chip reset
    always_ff @(posedge i_clk or negedge i_por_b) begin
        if (!i_por_b) begin
            pre_r <= 7'h00;
            us_r <= 8'h00;
            o_req <= 1'b0;
        end else begin
            pre_r <= tick ? 7'h00 : pre_r + 7'h01;
            if (lim == 8'h00 || due) begin
                us_r <= 8'h00;
            end else if (tick) begin
                us_r <= us_inc[7:0];
            end
            o_req <= due | (o_req & ~start); // new period wins over the grant
        end
    end

    // =====
    // sequencer: cas low, then ras low too, then ras recovery
    always_ff @(posedge i_clk or negedge i_por_b) begin
        if (!i_por_b) begin
            st_r <= dbi_pkg::R_IDLE;
            rec_r <= 3'h0;
        end else begin
            unique case (st_r)
                dbi_pkg::R_IDLE: if (start) st_r <= dbi_pkg::R_CAS;
                dbi_pkg::R_CAS: st_r <= dbi_pkg::R_BOTH;
                dbi_pkg::R_BOTH: begin
                    st_r <= dbi_pkg::R_REC;
                    rec_r <= 3'h1;
                end
                dbi_pkg::R_REC: begin
                    rec_r <= rec_r + 3'h1;
                    if (rec_r == dbi_pkg::REF_REC_CYC) st_r <= dbi_pkg::R_IDLE;
                end
            endcase
        end
    end

    assign o_busy = st_r != dbi_pkg::R_IDLE;
    assign o_cas = (st_r == dbi_pkg::R_CAS) | (st_r == dbi_pkg::R_BOTH);
    assign o_ras = st_r == dbi_pkg::R_BOTH;
endmodule // dbi_refresh

//--- core/dbi_dram_ctrl.sv
// four-bank fast page / edo dram controller with apb configuration
// Functional notes
// - one row strobe, bank from bits 27:26
// - 32-bit byte access: one column strobe
// - 32-bit row/column address multiplexing map
// - 16-bit row/column map, lsb generated
// - 16-bit mode shifts address up one
// - controller steps column lsb per half-word
// - page bursts up to 255 accesses
// - sequential access takes two clocks
// - non-sequential access five to nine clocks
// - four width bits, 1 means 16-bit
// - precharge 2 other bank, 3/4 same
// - ras-to-cas 2 clocks, 3 extended
// - latch read at cas end, edo later
// - cycle ends with ras low, cas high
// - timing bits read back, reset zero
// - force bits drive strobes low immediately
// - cas-before-ras refresh, four periods
// - one-hot period codes, reset 16us
// - refresh timer keeps running through reset
// - 16-bit word: upper half, then lower
`timescale 1ns/1ps
module dbi_dram_ctrl (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_POR_B,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [31:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_REQ_VALID,
    output logic O_REQ_READY,
    input wire logic [27:0] I_REQ_ADDR,
    input wire logic I_REQ_WRITE,
    input wire logic I_REQ_BYTE,
    input wire logic I_REQ_SEQ,
    input wire logic [31:0] I_REQ_WDATA,
    output logic O_RSP_DONE,
    output logic [31:0] O_RSP_RDATA,
    output logic [3:0] O_ROW_STROBE_N,
    output logic [3:0] O_COL_STROBE_N,
    output logic [11:0] O_DRAM_MUX_ADDR,
    output logic O_WE_N,
    input wire logic [31:0] I_DQ_IN,
    output logic [31:0] O_DQ_OUT,
    output logic O_DQ_OE
);
    // =====
    // address multiplexer; 16-bit banks use the address moved up one bit
    function automatic logic [11:0] mux_addr(input logic [27:0] a, input logic w16,
                                             input logic col, input logic hb);
        if (!w16) begin
            mux_addr = col ? {a[25], a[23], a[21], a[20], a[9:2]} : {a[24], a[22], a[19:10]};
        end else begin
            mux_addr = col ? {a[24], a[22], a[20], a[19], a[8:2], hb} : {a[23], a[21], a[18:9]};
        end
    endfunction

    logic [6:0] cfg;
    logic [7:0] force_v;
    logic [3:0] refp;
    logic ref_req;
    logic ref_busy;
    logic ref_ras;
    logic ref_cas;
    dbi_pkg::dbi_state_t state_r;
    dbi_pkg::dbi_state_t state_nxt;
    logic [27:0] acc_addr_r;
    logic acc_wr_r;
    logic acc_byte_r;
    logic acc_w16_r;
    logic half_r;
    logic go_r;
    logic [31:0] wdata_r;
    logic [7:0] burst_r;
    logic [1:0] cnt_r;
    logic [1:0] last_bank_r;
    logic [2:0] pre_cnt_r;
    logic [11:0] mux_r;
    logic [2:0] ctag_r;
    logic [3:0] lat1_r;
    logic [3:0] lat2_r;
    logic [31:0] dq_s1;
    logic [31:0] dq_s2;
    logic [31:0] rdata_r;
    logic done_r;

    // =====
    // configuration decode
    wire p_ext = cfg[dbi_pkg::CFG_PRE_BIT];
    wire r_ext = cfg[dbi_pkg::CFG_RCD_BIT];
    wire edo = cfg[dbi_pkg::CFG_EDO_BIT];
    wire req_w16 = cfg[I_REQ_ADDR[27:26]];
    wire [1:0] acc_bank = acc_addr_r[27:26];

    // =====
    // sequencing decode
    wire ras_act = (state_r == dbi_pkg::S_RAS) | (state_r == dbi_pkg::S_CAS) |
                   (state_r == dbi_pkg::S_TAIL) | (state_r == dbi_pkg::S_TAIL2);
    wire cas_act = state_r == dbi_pkg::S_CAS;
    wire [2:0] pre_need = (acc_bank != last_bank_r) ? dbi_pkg::PRE_DIFF :
                          (p_ext ? dbi_pkg::PRE_SAME_EXT : dbi_pkg::PRE_SAME);
    wire pre_ok = pre_cnt_r >= pre_need;
    wire [1:0] rcd_last = r_ext ? 2'(dbi_pkg::RCD_EXT - 2'h1) : 2'(dbi_pkg::RCD - 2'h1);
    wire upper = acc_w16_r & ~acc_byte_r & ~half_r;
    wire lower16 = acc_w16_r & ~acc_byte_r & half_r;
    wire [2:0] tag_cur = {upper, lower16, ~upper};
    wire hb_cur = acc_byte_r ? ~acc_addr_r[1] : half_r;
    // a new row is opened only with refresh quiet, so refresh never cuts in
    wire start_ok = (state_r == dbi_pkg::S_IDLE) & ~ref_req & ~ref_busy;
    wire cont_ok = cas_act & ~upper & I_REQ_SEQ & (I_REQ_ADDR[27:26] == acc_bank) &
                   (I_REQ_WRITE == acc_wr_r) & (burst_r < dbi_pkg::BURST_MAX) & ~ref_req;
    wire take = I_REQ_VALID & O_REQ_READY;
    wire ref_grant = (state_r == dbi_pkg::S_IDLE) &
                     (pre_cnt_r >= (p_ext ? dbi_pkg::PRE_SAME_EXT : dbi_pkg::PRE_SAME));
    // edo data is taken one clock later, in the tail after the column strobe
    wire cap_now = ~acc_wr_r & (edo ? (state_r == dbi_pkg::S_TAIL) : cas_act);
    wire [2:0] rd_tag = edo ? ctag_r : tag_cur;

    // =====
    // strobe and lane decode; force bits act combinationally
    wire [3:0] cas_mask = acc_w16_r ? (acc_byte_r ? 4'h1 << acc_addr_r[0] : 4'h3) :
                          (acc_byte_r ? 4'h1 << acc_addr_r[1:0] : 4'hF);
    wire [3:0] ras_vec = ras_act ? 4'h1 << acc_bank : 4'h0;
    wire [3:0] cas_vec = cas_act ? cas_mask : 4'h0;

    assign O_ROW_STROBE_N = ~(ras_vec | {4{ref_ras}} | force_v[3:0]);
    assign O_COL_STROBE_N = ~(cas_vec | {4{ref_cas}} | force_v[7:4]);
    assign O_DRAM_MUX_ADDR = mux_r;
    assign O_WE_N = ~(acc_wr_r & ras_act);
    assign O_DQ_OE = acc_wr_r & ras_act;
    // upper half-word sits at the lower column address
    assign O_DQ_OUT = acc_w16_r ? {16'h0000, hb_cur ? wdata_r[15:0] : wdata_r[31:16]} : wdata_r;
    assign O_REQ_READY = start_ok | cont_ok;
    assign O_RSP_DONE = done_r;
    assign O_RSP_RDATA = rdata_r;
    assign O_PREADY = 1'b1;

    // =====
    // next state: row setup, ras-to-cas, column, tail, edo write tail
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            dbi_pkg::S_IDLE: if (take) state_nxt = dbi_pkg::S_ROWA;
            dbi_pkg::S_ROWA: if (pre_ok) state_nxt = dbi_pkg::S_RAS;
            dbi_pkg::S_RAS: if (cnt_r == rcd_last) state_nxt = dbi_pkg::S_CAS;
            dbi_pkg::S_CAS: state_nxt = dbi_pkg::S_TAIL;
            dbi_pkg::S_TAIL: begin
                if (go_r) begin
                    state_nxt = dbi_pkg::S_CAS;
                end else if (edo && acc_wr_r) begin
                    state_nxt = dbi_pkg::S_TAIL2;
                end else begin
                    state_nxt = dbi_pkg::S_IDLE;
                end
            end
            dbi_pkg::S_TAIL2: state_nxt = dbi_pkg::S_IDLE;
        endcase
    end

    // state, counters and precharge tracking
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_r <= dbi_pkg::S_IDLE;
            cnt_r <= 2'h0;
            pre_cnt_r <= dbi_pkg::PRE_CNT_RST;
            last_bank_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= (state_r == dbi_pkg::S_RAS) ? cnt_r + 2'h1 : 2'h0;
            if (ras_act) begin
                pre_cnt_r <= 3'h1;
                last_bank_r <= acc_bank;
            end else if (pre_cnt_r != dbi_pkg::PRE_CNT_RST) begin
                pre_cnt_r <= pre_cnt_r + 3'h1;
            end
        end
    end

    // access registers loaded on each acceptance, first or sequential, not at the half-word step
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            acc_addr_r <= 28'h0000000;
            acc_wr_r <= 1'b0;
            acc_byte_r <= 1'b0;
            acc_w16_r <= 1'b0;
            wdata_r <= 32'h00000000;
            burst_r <= 8'h00;
        end else if (take) begin
            acc_addr_r <= I_REQ_ADDR;
            acc_wr_r <= I_REQ_WRITE;
            acc_byte_r <= I_REQ_BYTE;
            acc_w16_r <= req_w16;
            wdata_r <= I_REQ_WDATA;
            burst_r <= cas_act ? burst_r + 8'h01 : 8'h01;
        end
    end

    // multiplexed address and half-word stepping
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            mux_r <= 12'h000;
            half_r <= 1'b0;
            go_r <= 1'b0;
            ctag_r <= 3'h0;
        end else begin
            if (state_r == dbi_pkg::S_IDLE && take) begin
                mux_r <= mux_addr(I_REQ_ADDR, req_w16, 1'b0, 1'b0);
            end else if (state_r == dbi_pkg::S_RAS && cnt_r == 2'h0) begin
                mux_r <= mux_addr(acc_addr_r, acc_w16_r, 1'b1, hb_cur);
            end else if (cas_act && upper) begin
                mux_r <= mux_addr(acc_addr_r, acc_w16_r, 1'b1, 1'b1);
            end else if (cas_act && take) begin
                mux_r <= mux_addr(I_REQ_ADDR, acc_w16_r, 1'b1, I_REQ_BYTE & ~I_REQ_ADDR[1]);
            end
            if (state_r == dbi_pkg::S_IDLE) begin
                half_r <= 1'b0;
            end else if (cas_act) begin
                half_r <= upper;
                go_r <= take | upper;
                ctag_r <= tag_cur;
            end
        end
    end

    // read pin capture: two stages before any logic uses the data
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            dq_s1 <= 32'h00000000;
            dq_s2 <= 32'h00000000;
            lat1_r <= 4'h0;
            lat2_r <= 4'h0;
        end else begin
            dq_s1 <= I_DQ_IN;
            dq_s2 <= dq_s1;
            lat1_r <= {cap_now, rd_tag};
            lat2_r <= lat1_r;
        end
    end

    // read word assembly and completion pulse
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rdata_r <= 32'h00000000;
            done_r <= 1'b0;
        end else begin
            if (lat2_r[3] && lat2_r[2]) begin
                rdata_r[31:16] <= dq_s2[15:0];
            end else if (lat2_r[3] && lat2_r[1]) begin
                rdata_r[15:0] <= dq_s2[15:0];
            end else if (lat2_r[3]) begin
                rdata_r <= dq_s2;
            end
            done_r <= (lat2_r[3] & lat2_r[0]) | (cas_act & acc_wr_r & ~upper);
        end
    end

    // =====
    // submodules
    dbi_regs u_regs (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_psel(I_PSEL),
        .i_penable(I_PENABLE),
        .i_pwrite(I_PWRITE),
        .i_paddr(I_PADDR),
        .i_pwdata(I_PWDATA),
        .i_status({ras_act, ref_busy, state_r != dbi_pkg::S_IDLE}),
        .o_prdata(O_PRDATA),
        .o_pslverr(O_PSLVERR),
        .o_cfg(cfg),
        .o_force(force_v),
        .o_refp(refp)
    );

    dbi_refresh u_refresh (
        .i_clk(I_CLK),
        .i_por_b(I_POR_B),
        .i_period(refp),
        .i_grant(ref_grant),
        .o_req(ref_req),
        .o_busy(ref_busy),
        .o_ras(ref_ras),
        .o_cas(ref_cas)
    );

    // =====
    // assertions
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);

    a_ras_one_bank: assert property ((ras_act && force_v == 8'h00) |->
        (~O_ROW_STROBE_N == (4'h1 << acc_addr_r[27:26]))) else $error("row strobe bank wrong");
    a_byte_lane: assert property ((cas_act && acc_byte_r && !acc_w16_r && force_v == 8'h00) |->
        (~O_COL_STROBE_N == (4'h1 << acc_addr_r[1:0]))) else $error("byte lane wrong");
    a_w16_upper_idle: assert property ((acc_w16_r && !ref_cas && force_v == 8'h00) |->
        O_COL_STROBE_N[3:2] == 2'b11) else $error("upper strobes in 16-bit");
    a_half_lsb_step: assert property ((cas_act && upper) |=> ##1
        (cas_act && O_DRAM_MUX_ADDR[0])) else $error("second half lsb wrong");
    a_seq_two_clk: assert property ((cas_act && take) |=>
        !cas_act ##1 cas_act) else $error("sequential access not two clocks");
    a_rcd_short: assert property (($rose(ras_act) && !r_ext) |->
        !cas_act [*2] ##1 cas_act) else $error("ras-to-cas not 2");
    a_rcd_long: assert property (($rose(ras_act) && r_ext) |->
        !cas_act [*3] ##1 cas_act) else $error("ras-to-cas not 3");
    a_prech_gap: assert property ($rose(ras_act) |->
        $past(pre_cnt_r) >= $past(pre_need)) else $error("precharge too short");
    a_tail_ras_low: assert property ($fell(cas_act) |-> ras_act) else $error("no ras-low tail");
    a_fp_latch: assert property ((cas_act && !edo && !acc_wr_r) |=>
        lat1_r[3]) else $error("fast page latch late");
    a_edo_latch: assert property ((cas_act && edo && !acc_wr_r) |=>
        !lat1_r[3] ##1 lat1_r[3]) else $error("edo latch wrong");
    a_force_low: assert property (((force_v[3:0] & O_ROW_STROBE_N) == 4'h0) &&
        ((force_v[7:4] & O_COL_STROBE_N) == 4'h0)) else $error("forced strobe high");

    c_seq_burst: cover property (cas_act && take);
    c_refresh: cover property (ref_ras);
    c_w16_word: cover property (cas_act && lower16);
    c_edo_write_tail: cover property (state_r == dbi_pkg::S_TAIL2);
endmodule // dbi_dram_ctrl

//--- testbench/dbi_dram_model.sv
// partner model: four dram banks, row latched at its strobe fall
`timescale 1ns/1ps
module dbi_dram_model (
    input wire logic i_clk,
    input wire logic i_edo,
    input wire logic [3:0] i_row_n,
    input wire logic [3:0] i_col_n,
    input wire logic [11:0] i_addr,
    input wire logic i_we_n,
    input wire logic [31:0] i_dq,
    output logic [31:0] o_dq
);
    logic [31:0] mem [logic [25:0]];
    logic [11:0] row_r [4];
    logic [1:0] bank_r = 2'h0;
    logic [3:0] rp_r = 4'hF;
    logic [31:0] last_r = 32'h0;
    wire logic [25:0] key = {bank_r, row_r[bank_r], i_addr};
    wire logic rd = (i_col_n != 4'hF) && i_we_n;
    // =====
    // row capture and lane writes while a column strobe is low
    always @(posedge i_clk) begin
        rp_r <= i_row_n;
        for (int b = 0; b < 4; b++) begin
            if (rp_r[b] && !i_row_n[b]) begin
                bank_r <= b[1:0];
                row_r[b] <= i_addr;
            end
        end
        if (rd) last_r <= o_dq;
        if (!i_we_n && i_col_n != 4'hF) begin
            if (!mem.exists(key)) mem[key] = 32'h0;
            for (int l = 0; l < 4; l++) if (!i_col_n[l]) mem[key][8*l+:8] = i_dq[8*l+:8];
        end
    end
    // released bus shows no stale data; edo parts hold it until the row closes
    always @* begin
        if (rd) o_dq = mem.exists(key) ? mem[key] : 32'h0;
        else if (i_edo && i_row_n != 4'hF) o_dq = last_r;
        else o_dq = ~last_r;
    end
endmodule // dbi_dram_model

//--- testbench/dbi_dram_ctrl_tb.sv
// self-checking bench for the dram bank interface controller
`timescale 1ns/1ps
module dbi_dram_ctrl_tb;
    typedef struct {logic [6:0] cfg; logic [27:0] a; logic b; logic [31:0] d;} dbi_row_t;
    logic clk = 1'b0, rst_b = 1'b0, por_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic rv = 1'b0, rwr = 1'b0, rbyte = 1'b0, rseq = 1'b0, edo = 1'b0, h, err, first;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, rwd = 32'h0, prdata, rrd, dqi, dqo, q, m;
    logic [27:0] raddr = 28'h0;
    logic pready, pslverr, rrdy, done, we_n, oe;
    logic [3:0] row_n, col_n, rp = 4'hF, cp = 4'hF, bank_s, cas_s;
    logic [11:0] mux, row_s, col_s;
    int cyc, t_ras, t_rise, t_cas, t_ref, gap, rcd, sgap, row_strobe_n, nref, ref_iv, n0, n_mismatch, tests_run;
    dbi_row_t tbl [6] = '{'{7'h00, 28'h0000104, 1'b0, 32'hA5A50F0F}, '{7'h70, 28'h6ABCDE8, 1'b0, 32'h3C3C9696},
        '{7'h04, 28'h8F0F0F0, 1'b0, 32'h12345678}, '{7'h28, 28'hFFFFFFC, 1'b0, 32'hCAFE5AA5},
        '{7'h10, 28'h4000003, 1'b1, 32'h5A000000}, '{7'h40, 28'h0000001, 1'b1, 32'h0000C300}};
    always #20 clk = ~clk;
    dbi_dram_ctrl DUT (.I_CLK(clk), .I_RST_B(rst_b), .I_POR_B(por_b), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_REQ_VALID(rv), .O_REQ_READY(rrdy), .I_REQ_ADDR(raddr), .I_REQ_WRITE(rwr),
        .I_REQ_BYTE(rbyte), .I_REQ_SEQ(rseq), .I_REQ_WDATA(rwd), .O_RSP_DONE(done), .O_RSP_RDATA(rrd),
        .O_ROW_STROBE_N(row_n), .O_COL_STROBE_N(col_n), .O_DRAM_MUX_ADDR(mux), .O_WE_N(we_n),
        .I_DQ_IN(dqi), .O_DQ_OUT(dqo), .O_DQ_OE(oe));
    dbi_dram_model mdl (.i_clk(clk), .i_edo(edo), .i_row_n(row_n), .i_col_n(col_n), .i_addr(mux),
        .i_we_n(we_n), .i_dq(oe ? dqo : ~dqo), .o_dq(dqi)); // lanes count only while driven
    // =====
    // strobe monitor: refresh shows column strobes falling while rows are idle
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rp <= row_n;
        cp <= col_n;
        if (rp != 4'hF && row_n == 4'hF) t_rise <= cyc;
        if (rp == 4'hF && row_n != 4'hF && col_n == 4'hF) begin
            {row_strobe_n, t_ras, gap, bank_s, row_s, first} <= {row_strobe_n + 1, cyc, cyc - t_rise, row_n, mux, 1'b1};
        end
        if (cp == 4'hF && col_n != 4'hF && row_n != 4'hF) begin
            t_cas <= cyc;
            first <= 1'b0;
            if (first) {rcd, cas_s, col_s} <= {cyc - t_ras, col_n, mux};
            else sgap <= cyc - t_cas;
        end
        if (cp == 4'hF && col_n == 4'h0 && row_n == 4'hF) {nref, ref_iv, t_ref} <= {nref + 1, cyc - t_ref, cyc};
    end
    // =====
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {r, err} = {prdata, pslverr};
        {psel, pen} <= 2'b00;
    endtask
    // requests are held until taken; done is awaited under a bound
    task automatic mem(input logic [27:0] a, input logic w, input logic b, input logic [31:0] d);
        @(posedge clk);
        {rv, raddr, rwr, rbyte, rwd} <= {1'b1, a, w, b, d};
        do @(posedge clk); while (rrdy !== 1'b1);
        rv <= 1'b0;
        for (int i = 0; i < 40 && done !== 1'b1; i++) @(posedge clk);
        q = rrd;
    endtask
    task automatic burst(input logic [27:0] a, input int n);
        @(posedge clk);
        {rv, rseq, rwr, rbyte, raddr, rwd} <= {3'b111, 1'b0, a, 32'(a)};
        for (int i = 1; i <= n; i++) begin
            do @(posedge clk); while (rrdy !== 1'b1);
            {raddr, rwd} <= {a + 28'(4 * i), 32'(a + 28'(4 * i))};
        end
        {rv, rseq} <= 2'b00;
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
    // =====
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        {por_b, rst_b} <= 2'b11;
        apb(0, dbi_pkg::ADDR_CFG, 0, q);
        chk("cfg", q, 32'(dbi_pkg::CFG_RST));
        apb(0, dbi_pkg::ADDR_FORCE, 0, q);
        chk("force", q, 32'(dbi_pkg::FORCE_RST));
        apb(0, dbi_pkg::ADDR_REFP, 0, q);
        chk("refp", q, 32'h1);
        apb(1, dbi_pkg::ADDR_REFP, 0, q);
        apb(1, dbi_pkg::ADDR_CFG, 32'hFF, q);
        apb(0, dbi_pkg::ADDR_CFG, 0, q);
        chk("cfg", q, 32'h7F);
        apb(0, 32'h032000DC, 0, q);
        chk("err", {q[30:0], err}, 32'h1);
        apb(1, dbi_pkg::ADDR_FORCE, 32'h21, q);
        @(posedge clk);
        chk("frow", row_n, 4'hE);
        chk("fcol", col_n, 4'hD);
        apb(1, dbi_pkg::ADDR_FORCE, 0, q);
        $display("register test done");
        foreach (tbl[i]) begin
            h = tbl[i].cfg[tbl[i].a[27:26]];
            m = tbl[i].b ? 32'hFF << (8 * tbl[i].a[1:0]) : 32'hFFFFFFFF;
            edo <= tbl[i].cfg[4];
            apb(1, dbi_pkg::ADDR_CFG, 32'(tbl[i].cfg), q);
            mem(tbl[i].a, 1, tbl[i].b, tbl[i].d);
            mem(tbl[i].a, 0, tbl[i].b, 0);
            chk("rdata", q & m, tbl[i].d & m);
            chk("bank", bank_s, 4'(~(4'h1 << tbl[i].a[27:26])));
            chk("row", row_s, h ? {tbl[i].a[23], tbl[i].a[21], tbl[i].a[18:9]}
                : {tbl[i].a[24], tbl[i].a[22], tbl[i].a[19:10]});
            chk("col", col_s, h ? {tbl[i].a[24], tbl[i].a[22], tbl[i].a[20:19], tbl[i].a[8:2], 1'b0}
                : {tbl[i].a[25], tbl[i].a[23], tbl[i].a[21:20], tbl[i].a[9:2]});
            chk("cas", cas_s, h ? 4'hC : tbl[i].b ? 4'(~(4'h1 << tbl[i].a[1:0])) : 4'h0);
            chk("rcd", rcd, tbl[i].cfg[5] ? 3 : 2);
            chk("pre", gap >= (tbl[i].cfg[6] ? 4 : 3), 1);
            $display("access row %0d done", i);
        end
        apb(1, dbi_pkg::ADDR_CFG, 0, q);
        edo <= 1'b0;
        n0 = row_strobe_n;
        burst(28'h4000000, 256);
        mem(28'h40003FC, 0, 0, 0);
        chk("bdata", q, 32'h40003FC);
        chk("row_strobe_n", row_strobe_n - n0, 3);
        n0 = row_strobe_n;
        burst(28'h4000400, 3);
        mem(28'h4000404, 0, 0, 0);
        chk("row_strobe_n", row_strobe_n - n0, 2);
        chk("sgap", sgap, 2);
        $display("burst test done");
        for (int k = 0; k < 4; k++) begin
            apb(1, dbi_pkg::ADDR_REFP, 32'h1 << k, q);
            n0 = nref;
            for (int i = 0; i < 10000 && nref < n0 + 2; i++) @(posedge clk);
            chk("refiv", (ref_iv - (16 << k) * dbi_pkg::US_CYC) inside {[-2:2]}, 1);
        end
        apb(1, dbi_pkg::ADDR_REFP, 0, q);
        n0 = nref;
        repeat (1000) @(posedge clk);
        chk("refoff", nref - n0, 0);
        rst_b <= 1'b0;
        repeat (900) @(posedge clk);
        chk("refrst", nref - n0 >= 2, 1);
        rst_b <= 1'b1;
        apb(0, dbi_pkg::ADDR_REFP, 0, q);
        chk("refp", q, 32'h1);
        $display("refresh test done");
        stop_test();
    end
endmodule // dbi_dram_ctrl_tb
